// file: core/smb_pkg.sv
`default_nettype none
package smb_pkg;
    // ------------------------------------------------------------
    // memory map
    // ------------------------------------------------------------
    localparam int ADDR_W = 20;
    localparam int BANK_COUNT = 10;
    localparam logic [3:0] BANK_LIMIT = 4'ha;
    localparam int BANK_LSB = 16;
    localparam int SRAM_HI_LSB = 14;
    localparam logic [3:0] EXP_NONE = 4'hf;
    localparam logic [3:0] EXP_LAST = 4'he;

    // ------------------------------------------------------------
    // control port snooped on i/o writes
    // ------------------------------------------------------------
    localparam logic [15:0] ACK_CTRL_IO_ADDR = 16'h0065;
    localparam int ACK_CTRL_EN_BIT = 0;
    localparam logic ACK_CTRL_RESET = 1'b0;

    // ------------------------------------------------------------
    // bus cycle phases counted after the address latch strobe
    // ------------------------------------------------------------
    localparam logic [1:0] PH_IDLE = 2'h0;
    localparam logic [1:0] PH_T2 = 2'h1;
    localparam logic [1:0] PH_T3 = 2'h2;
    localparam logic [1:0] PH_T4 = 2'h3;

    // ------------------------------------------------------------
    // strap meaning and arbitration
    // ------------------------------------------------------------
    localparam logic STRAP_STATIC = 1'b0;

    typedef enum logic [2:0] {
        SMB_ARB_IDLE,
        SMB_ARB_REQ,
        SMB_ARB_WAIT,
        SMB_ARB_OWN,
        SMB_ARB_REL
    } smb_arb_t;
endpackage
`default_nettype wire

// file: core/smb_sram_if.sv
`default_nettype none
module smb_sram_if
    import smb_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic mem_type_strap_in,
    input wire logic copro_fitted_in,
    input wire logic copro_busy_n_in,
    input wire logic io_channel_check_in,
    input wire logic copro_exception_in,
    input wire logic nmi_clear_in,
    input wire logic ale_in,
    input wire logic mem_rd_in,
    input wire logic mem_wr_in,
    input wire logic io_rd_in,
    input wire logic io_wr_in,
    input wire logic dma_req_in,
    input wire logic dma_done_in,
    input wire logic dma_addr_phase_in,
    input wire logic [19:0] dma_addr_in,
    input wire logic dma_bhe_n_in,
    input wire logic exp_select_in,
    input wire logic [3:0] exp_bank_in,
    input wire logic refresh_cycle_in,
    input wire logic [3:0] upper_sys_addr_in,
    output logic [3:0] upper_sys_addr_out,
    output logic upper_sys_addr_oe_out,
    input wire logic [15:0] muxed_addr_data_in,
    output logic [15:0] muxed_addr_data_out,
    output logic muxed_addr_data_oe_out,
    input wire logic byte_high_enable_n_in,
    output logic byte_high_enable_n_out,
    output logic byte_high_enable_n_oe_out,
    input wire logic copro_req_grant_in,
    output logic copro_req_grant_out,
    output logic copro_req_grant_oe_out,
    input wire logic cpu_req_grant_in,
    output logic cpu_req_grant_out,
    output logic cpu_req_grant_oe_out,
    input wire logic [1:0] byte_parity_bits_in,
    output logic [1:0] byte_parity_bits_out,
    output logic byte_parity_bits_oe_out,
    output logic dma_grant_out,
    output logic latched_addr_bit0_out,
    output logic sys_ready_out,
    output logic nmi_out,
    output logic mem_direction_out,
    output logic [9:0] base_bank_select_n_out,
    output logic [3:0] exp_bank_code_out,
    output logic [1:0] static_upper_addr_out,
    output logic static_write_hi_n_out,
    output logic static_write_lo_n_out,
    output logic static_read_strobe_n_out,
    output logic ack_gate_n_out,
    output logic refresh_indicator_n_out
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [4:0] sync1_q;
    logic [4:0] sync2_q;
    logic static_mode;
    logic copro_fitted;
    logic copro_busy;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            // reset leans to dynamic so static strobes stay idle
            sync1_q <= 5'h03;
            sync2_q <= 5'h03;
        end else begin
            sync1_q <= {copro_exception_in, io_channel_check_in,
                        copro_fitted_in, copro_busy_n_in,
                        mem_type_strap_in};
            sync2_q <= sync1_q;
        end
    end

    assign static_mode = (sync2_q[0] == STRAP_STATIC);
    assign copro_busy = !sync2_q[1];
    assign copro_fitted = sync2_q[2];

    // ------------------------------------------------------------
    // bus arbitration for dma ownership
    // ------------------------------------------------------------
    smb_arb_t arb_q;
    logic own;
    logic chan_in;
    logic req_pulse;

    assign chan_in = copro_fitted ? copro_req_grant_in : cpu_req_grant_in;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            arb_q <= SMB_ARB_IDLE;
        end else begin
            case (arb_q)
                SMB_ARB_IDLE: begin
                    // a busy coprocessor is left its bus until done
                    if (dma_req_in && !copro_busy) begin
                        arb_q <= SMB_ARB_REQ;
                    end
                end
                SMB_ARB_REQ: begin
                    arb_q <= SMB_ARB_WAIT;
                end
                SMB_ARB_WAIT: begin
                    if (!chan_in) begin
                        arb_q <= SMB_ARB_OWN;
                    end
                end
                SMB_ARB_OWN: begin
                    if (dma_done_in) begin
                        arb_q <= SMB_ARB_REL;
                    end
                end
                SMB_ARB_REL: begin
                    arb_q <= SMB_ARB_IDLE;
                end
                default: begin
                    arb_q <= SMB_ARB_IDLE;
                end
            endcase
        end
    end

    assign own = (arb_q == SMB_ARB_OWN);
    assign dma_grant_out = own;
    assign req_pulse = (arb_q == SMB_ARB_REQ) || (arb_q == SMB_ARB_REL);

    // request and release are both one low clock on one channel
    assign copro_req_grant_oe_out = req_pulse && copro_fitted;
    assign copro_req_grant_out = 1'b0;
    assign cpu_req_grant_oe_out = req_pulse && !copro_fitted;
    assign cpu_req_grant_out = 1'b0;

    // ------------------------------------------------------------
    // address drive while the dma owns the bus
    // ------------------------------------------------------------
    assign upper_sys_addr_oe_out = own;
    assign upper_sys_addr_out = dma_addr_in[19:16];
    assign muxed_addr_data_oe_out = own && dma_addr_phase_in;
    assign muxed_addr_data_out = dma_addr_in[15:0];
    assign byte_high_enable_n_oe_out = own;
    assign byte_high_enable_n_out = dma_bhe_n_in;

    // ------------------------------------------------------------
    // cycle latch and phase counter
    // ------------------------------------------------------------
    logic [19:0] addr_q;
    logic bhe_n_q;
    logic a0_q;
    logic rd_q;
    logic wr_q;
    logic io_wr_q;
    logic io_rd_q;
    logic exp_q;
    logic [3:0] exp_bank_q;
    logic [1:0] ph_q;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            addr_q <= 20'h00000;
            bhe_n_q <= 1'b1;
            a0_q <= 1'b0;
        end else if (ale_in) begin
            if (own) begin
                addr_q <= dma_addr_in;
                bhe_n_q <= dma_bhe_n_in;
                a0_q <= dma_addr_in[0];
            end else begin
                addr_q <= {upper_sys_addr_in, muxed_addr_data_in};
                bhe_n_q <= byte_high_enable_n_in;
                a0_q <= muxed_addr_data_in[0];
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            io_rd_q <= 1'b0;
            io_wr_q <= 1'b0;
            exp_q <= 1'b0;
            exp_bank_q <= EXP_NONE;
        end else if (ale_in) begin
            rd_q <= mem_rd_in;
            wr_q <= mem_wr_in;
            io_rd_q <= io_rd_in;
            io_wr_q <= io_wr_in;
            exp_q <= exp_select_in && (exp_bank_in <= EXP_LAST);
            exp_bank_q <= exp_bank_in;
        end else if (ph_q == PH_T4) begin
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            io_rd_q <= 1'b0;
            io_wr_q <= 1'b0;
            exp_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ph_q <= PH_IDLE;
        end else if (ale_in) begin
            ph_q <= PH_T2;
        end else if (ph_q != PH_IDLE) begin
            ph_q <= ph_q + 2'h1;
        end
    end

    // ------------------------------------------------------------
    // decode and strobes
    // ------------------------------------------------------------
    logic data_ph;
    logic in_base;
    logic base_acc;
    logic exp_acc;

    assign data_ph = (ph_q == PH_T2) || (ph_q == PH_T3);
    assign in_base = (addr_q[19:16] < BANK_LIMIT) && !exp_q;
    assign base_acc = static_mode && in_base && (rd_q || wr_q) && data_ph;
    assign exp_acc = static_mode && exp_q && (rd_q || wr_q) && data_ph;

    always_comb begin
        base_bank_select_n_out = '1;
        for (int i = 0; i < BANK_COUNT; i++) begin
            // one select per 64K region below the top of base memory
            if (base_acc && (addr_q[19:16] == 4'(i))) begin
                base_bank_select_n_out[i] = 1'b0;
            end
        end
    end

    assign exp_bank_code_out = exp_acc ? exp_bank_q
        : EXP_NONE;
    assign static_upper_addr_out = static_mode ?
        addr_q[SRAM_HI_LSB +: 2] : 2'h0;
    assign latched_addr_bit0_out = a0_q;

    // bhe low selects the upper lane, a0 low the lower lane
    assign static_write_hi_n_out = !((base_acc || exp_acc) && wr_q
        && !bhe_n_q);
    assign static_write_lo_n_out = !((base_acc || exp_acc) && wr_q
        && !a0_q);
    assign static_read_strobe_n_out = !((base_acc || exp_acc)
        && rd_q);
    assign mem_direction_out = wr_q && data_ph;

    // zero wait: the transfer completes in T3
    assign sys_ready_out = (ph_q == PH_T3)
        && (rd_q || wr_q || io_rd_q || io_wr_q);

    // refresh never reaches the pin with static memory fitted
    assign refresh_indicator_n_out = !(refresh_cycle_in
        && !static_mode);

    // ------------------------------------------------------------
    // parity
    // ------------------------------------------------------------
    logic par_err;

    assign byte_parity_bits_oe_out = wr_q && data_ph && (base_acc || exp_acc);
    assign byte_parity_bits_out = {~^muxed_addr_data_in[15:8],
                                   ~^muxed_addr_data_in[7:0]};

    // checked only on reads: a write just set the bits itself
    assign par_err = (ph_q == PH_T3) && rd_q && (base_acc || exp_acc) && (
        (!bhe_n_q && !(^{muxed_addr_data_in[15:8], byte_parity_bits_in[1]}))
        || (!a0_q && !(^{muxed_addr_data_in[7:0], byte_parity_bits_in[0]})));

    // ------------------------------------------------------------
    // non-maskable interrupt, held until cleared; a new cause wins
    // ------------------------------------------------------------
    logic nmi_q;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            nmi_q <= 1'b0;
        end else if (par_err || sync2_q[3] || sync2_q[4]) begin
            nmi_q <= 1'b1;
        end else if (nmi_clear_in) begin
            nmi_q <= 1'b0;
        end
    end

    assign nmi_out = nmi_q;

    // ------------------------------------------------------------
    // acknowledge gate, set by i/o writes to its control port
    // ------------------------------------------------------------
    logic ack_en_q;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ack_en_q <= ACK_CTRL_RESET;
        end else if (io_wr_q && (ph_q == PH_T3)
                     && (addr_q[15:0] == ACK_CTRL_IO_ADDR)) begin
            ack_en_q <= muxed_addr_data_in[ACK_CTRL_EN_BIT];
        end
    end

    assign ack_gate_n_out = !ack_en_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_req_then_wait;
        arb_q == SMB_ARB_REQ ##1 arb_q == SMB_ARB_WAIT;
    endsequence

    sequence s_rel_then_idle;
        arb_q == SMB_ARB_REL ##1 arb_q == SMB_ARB_IDLE;
    endsequence

    a_strap_dynamic_idle: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        !static_mode |-> (&base_bank_select_n_out && static_read_strobe_n_out
            && static_write_hi_n_out && static_write_lo_n_out))
        else $error("static strobe active in dynamic mode");

    a_bank_select_map: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        base_acc |-> (base_bank_select_n_out
            == ~(10'h001 << addr_q[19:16])))
        else $error("bank select does not match address");

    a_exp_code_idle: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        !exp_acc |-> exp_bank_code_out == 4'hf)
        else $error("expanded code not all ones when idle");

    a_no_strobe_outside: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        (addr_q[19:16] >= 4'ha) && !exp_q |->
            &base_bank_select_n_out && static_write_hi_n_out
            && static_write_lo_n_out)
        else $error("strobe outside base range");

    a_ready_in_t3: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        ale_in && (mem_rd_in || mem_wr_in) ##1 !ale_in [*2]
            |-> sys_ready_out)
        else $error("ready missing in T3");

    a_req_pulse_one: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        s_req_then_wait |-> !copro_req_grant_oe_out && !cpu_req_grant_oe_out)
        else $error("request pulse longer than one clock");

    a_cpu_chan_quiet: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        copro_fitted |-> !cpu_req_grant_oe_out)
        else $error("cpu channel driven with coprocessor fitted");

    a_release_lines: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        s_rel_then_idle |-> !upper_sys_addr_oe_out
            && !byte_high_enable_n_oe_out && !muxed_addr_data_oe_out)
        else $error("lines still driven after release");

    a_nmi_from_parity: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        par_err |=> nmi_out [*2])
        else $error("parity error did not raise nmi");

    a_busy_blocks_req: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        arb_q == SMB_ARB_IDLE && copro_busy |=> arb_q != SMB_ARB_REQ)
        else $error("request issued while coprocessor busy");

    a_refresh_quiet: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        static_mode |-> refresh_indicator_n_out)
        else $error("refresh shown in static mode");
endmodule
`default_nettype wire

// file: verification/smb_rqgt_model.sv
`default_nettype none
// ------------------------------------------------------------
// request/grant channel partner: a pull-up holds the line high
// ------------------------------------------------------------
module smb_rqgt_model (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic dev_oe_in,
    input wire logic dev_level_in,
    input wire logic [3:0] grant_delay_in,
    output logic line_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] wait_q;
    logic pend_q;
    logic owned_q;
    logic grant_q;
    assign line_out = dev_oe_in ? dev_level_in : !grant_q;
    // first pulse asks, one grant pulse answers, next pulse hands back
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pend_q <= 1'b0;
            owned_q <= 1'b0;
            wait_q <= 4'h0;
            grant_q <= 1'b0;
        end else begin
            grant_q <= 1'b0;
            if (dev_oe_in && !dev_level_in && owned_q) begin
                owned_q <= 1'b0;
            end else if (dev_oe_in && !dev_level_in && !pend_q) begin
                pend_q <= 1'b1;
                wait_q <= grant_delay_in;
            end else if (pend_q && wait_q != 4'h0) begin
                wait_q <= wait_q - 4'h1;
            end else if (pend_q) begin
                grant_q <= 1'b1;
                pend_q <= 1'b0;
                owned_q <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// file: verification/sram_memory_bus_interface_bench.sv
`default_nettype none
module sram_memory_bus_interface_bench
    import smb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_in = 1'b0, rst_n_in = 1'b0, mem_type_strap_in = 1'b0;
    logic copro_fitted_in = 1'b1, copro_busy_n_in = 1'b1;
    logic io_channel_check_in = 1'b0, copro_exception_in = 1'b0;
    logic nmi_clear_in = 1'b0, ale_in = 1'b0, mem_rd_in = 1'b0;
    logic mem_wr_in = 1'b0, io_rd_in = 1'b0, io_wr_in = 1'b0;
    logic dma_req_in = 1'b0, dma_done_in = 1'b0, dma_addr_phase_in = 1'b0;
    logic dma_bhe_n_in = 1'b1, exp_select_in = 1'b0, refresh_cycle_in = 1'b0;
    logic [19:0] dma_addr_in = 20'h00000;
    logic [3:0] exp_bank_in = 4'h0, tb_up = 4'h0, gnt_dly = 4'h0;
    logic [15:0] tb_ad = 16'h0000;
    logic [1:0] tb_par = 2'h0;
    logic tb_bhe_n = 1'b1;
    logic [3:0] upper_sys_addr_in, upper_sys_addr_out, exp_bank_code_out;
    logic [15:0] muxed_addr_data_in, muxed_addr_data_out;
    logic [1:0] byte_parity_bits_in, byte_parity_bits_out;
    logic [1:0] static_upper_addr_out;
    logic [9:0] base_bank_select_n_out;
    logic upper_sys_addr_oe_out, muxed_addr_data_oe_out;
    logic byte_high_enable_n_in, byte_high_enable_n_out;
    logic byte_high_enable_n_oe_out, byte_parity_bits_oe_out;
    logic copro_req_grant_in, copro_req_grant_out, copro_req_grant_oe_out;
    logic cpu_req_grant_in, cpu_req_grant_out, cpu_req_grant_oe_out;
    logic dma_grant_out, latched_addr_bit0_out, sys_ready_out, nmi_out;
    logic mem_direction_out, static_write_hi_n_out, static_write_lo_n_out;
    logic static_read_strobe_n_out, ack_gate_n_out, refresh_indicator_n_out;
    int bad_count = 0, n_checks = 0, cycles = 0, n_cop = 0, n_cpu = 0;

    // ------------------------------------------------------------
    // shared lines: whoever enables wins, else the bench's value
    // ------------------------------------------------------------
    assign upper_sys_addr_in = upper_sys_addr_oe_out ? upper_sys_addr_out
        : tb_up;
    assign muxed_addr_data_in = muxed_addr_data_oe_out ? muxed_addr_data_out
        : tb_ad;
    assign byte_high_enable_n_in = byte_high_enable_n_oe_out
        ? byte_high_enable_n_out : tb_bhe_n;
    assign byte_parity_bits_in = byte_parity_bits_oe_out
        ? byte_parity_bits_out : tb_par;

    smb_sram_if i_dut (.clk_in, .rst_n_in, .mem_type_strap_in,
        .copro_fitted_in, .copro_busy_n_in, .io_channel_check_in,
        .copro_exception_in, .nmi_clear_in, .ale_in, .mem_rd_in, .mem_wr_in,
        .io_rd_in, .io_wr_in, .dma_req_in, .dma_done_in, .dma_addr_phase_in,
        .dma_addr_in, .dma_bhe_n_in, .exp_select_in, .exp_bank_in,
        .refresh_cycle_in, .upper_sys_addr_in, .upper_sys_addr_out,
        .upper_sys_addr_oe_out, .muxed_addr_data_in, .muxed_addr_data_out,
        .muxed_addr_data_oe_out, .byte_high_enable_n_in,
        .byte_high_enable_n_out, .byte_high_enable_n_oe_out,
        .copro_req_grant_in, .copro_req_grant_out, .copro_req_grant_oe_out,
        .cpu_req_grant_in, .cpu_req_grant_out, .cpu_req_grant_oe_out,
        .byte_parity_bits_in, .byte_parity_bits_out, .byte_parity_bits_oe_out,
        .dma_grant_out, .latched_addr_bit0_out, .sys_ready_out, .nmi_out,
        .mem_direction_out, .base_bank_select_n_out, .exp_bank_code_out,
        .static_upper_addr_out, .static_write_hi_n_out, .static_write_lo_n_out,
        .static_read_strobe_n_out, .ack_gate_n_out, .refresh_indicator_n_out);
    smb_rqgt_model i_cop (.clk_in, .rst_n_in, .grant_delay_in(gnt_dly),
        .dev_oe_in(copro_req_grant_oe_out), .dev_level_in(copro_req_grant_out),
        .line_out(copro_req_grant_in));
    smb_rqgt_model i_cpu (.clk_in, .rst_n_in, .grant_delay_in(gnt_dly),
        .dev_oe_in(cpu_req_grant_oe_out), .dev_level_in(cpu_req_grant_out),
        .line_out(cpu_req_grant_in));

    always #5 clk_in = ~clk_in;

    // counts request and release pulses per channel; also cuts a hang short
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        n_cop <= n_cop + int'(copro_req_grant_oe_out);
        n_cpu <= n_cpu + int'(cpu_req_grant_oe_out);
        if (cycles == 5000) begin
            bad_count++;
            stop_test();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic stop_test();
        $display("checks=%0d mismatches=%0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // bus cycle: returns in T2, address latched at the ale edge
    // ------------------------------------------------------------
    task automatic drive(input logic [3:0] k, input logic [19:0] a,
        input logic bhe_n, input logic xs, input logic [3:0] xb,
        input logic [15:0] d, input logic [1:0] p);
        @(posedge clk_in);
        ale_in <= 1'b1;
        {io_wr_in, io_rd_in, mem_wr_in, mem_rd_in} <= k;
        {tb_up, tb_ad} <= a;
        tb_bhe_n <= bhe_n;
        exp_select_in <= xs;
        exp_bank_in <= xb;
        @(posedge clk_in);
        ale_in <= 1'b0;
        tb_ad <= d;
        tb_par <= p;
        @(negedge clk_in);
    endtask

    task automatic mem_cyc(input logic wr, input logic [19:0] a,
        input logic bhe_n, input logic xs, input logic [3:0] xb,
        input logic [15:0] d, input logic bad);
        logic st, base, acc;
        logic [9:0] sel;
        logic [1:0] p;
        st = !mem_type_strap_in;
        base = st && !xs && a < 20'ha0000;
        acc = base || (st && xs && xb <= EXP_LAST);
        sel = base ? ~(10'h001 << a[19:16]) : 10'h3ff;
        p = {~^d[15:8], ~^d[7:0]} ^ {1'b0, bad};
        drive({2'b00, wr, !wr}, a, bhe_n, xs, xb, d, p);
        chk(base_bank_select_n_out, sel);
        chk(static_write_hi_n_out, !(acc && wr && !bhe_n));
        chk(static_write_lo_n_out, !(acc && wr && !a[0]));
        chk(static_read_strobe_n_out, !(acc && !wr));
        chk(mem_direction_out, wr);
        chk(static_upper_addr_out, st ? a[15:14] : 2'h0);
        chk(latched_addr_bit0_out, a[0]);
        chk(exp_bank_code_out, (acc && xs) ? xb : EXP_NONE);
        if (wr) begin
            chk({byte_parity_bits_oe_out, byte_parity_bits_out},
                {acc, p});
        end
        @(negedge clk_in);
        chk(sys_ready_out, 1'b1);
        @(negedge clk_in);
        chk({sys_ready_out, base_bank_select_n_out}, 11'h3ff);
        chk(exp_bank_code_out, EXP_NONE);
        chk(nmi_out, bad);
        @(posedge clk_in);
        {mem_wr_in, mem_rd_in, exp_select_in} <= 3'h0;
    endtask

    task automatic io_cyc(input logic [15:0] a, input logic [15:0] d);
        drive(4'h8, {4'h0, a}, 1'b1, 1'b0, 4'h0, d, 2'h0);
        chk({base_bank_select_n_out, static_write_lo_n_out},
            11'h7ff);
        @(negedge clk_in);
        chk(sys_ready_out, 1'b1);
        @(posedge clk_in);
        @(posedge clk_in);
        io_wr_in <= 1'b0;
        @(negedge clk_in);
    endtask

    task automatic clr_nmi();
        @(posedge clk_in);
        nmi_clear_in <= 1'b1;
        @(posedge clk_in);
        nmi_clear_in <= 1'b0;
        @(negedge clk_in);
        chk(nmi_out, 1'b0);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_mem();
        logic [19:0] a;
        for (int n = 0; n <= 10; n++) begin
            a = {n[3:0], n[0] ? 16'hffff : 16'h4000};
            mem_cyc(1'b1, a, n[1] & ~a[0], 1'b0, 4'h0,
                16'h1234 + 16'(n), 1'b0);
        end
        for (int b = 0; b < 16; b++) begin
            mem_cyc(1'b1, 20'hd4000 | 20'(b), 1'b0, 1'b1, b[3:0],
                16'h8001, 1'b0);
        end
        mem_cyc(1'b0, 20'h4c001, 1'b0, 1'b0, 4'h0, 16'hbeef, 1'b0);
        mem_cyc(1'b0, 20'h9fffe, 1'b1, 1'b0, 4'h0, 16'h7f00, 1'b1);
        clr_nmi();
        $display("test memory cycles done");
    endtask

    task automatic t_io();
        io_cyc(ACK_CTRL_IO_ADDR, 16'h0001);
        chk(ack_gate_n_out, 1'b0);
        io_cyc(16'h0066, 16'h0000);
        chk(ack_gate_n_out, 1'b0);
        io_cyc(ACK_CTRL_IO_ADDR, 16'h00fe);
        chk(ack_gate_n_out, 1'b1);
        $display("test control port done");
    endtask

    task automatic t_nmi();
        for (int k = 0; k < 2; k++) begin
            @(posedge clk_in);
            {copro_exception_in, io_channel_check_in} <= k[0] ? 2'h2 : 2'h1;
            repeat (5) @(posedge clk_in);
            nmi_clear_in <= 1'b1;
            @(posedge clk_in);
            @(negedge clk_in);
            chk(nmi_out, 1'b1);
            @(posedge clk_in);
            {copro_exception_in, io_channel_check_in, nmi_clear_in} <= 3'h0;
            repeat (4) @(posedge clk_in);
            clr_nmi();
        end
        $display("test nmi done");
    endtask

    task automatic t_mode();
        @(posedge clk_in);
        mem_type_strap_in <= 1'b1;
        refresh_cycle_in <= 1'b1;
        repeat (5) @(negedge clk_in);
        chk(refresh_indicator_n_out, 1'b0);
        mem_cyc(1'b1, 20'h30000, 1'b0, 1'b0, 4'h0, 16'h00ff, 1'b0);
        mem_type_strap_in <= 1'b0;
        repeat (5) @(negedge clk_in);
        chk(refresh_indicator_n_out, 1'b1);
        @(posedge clk_in);
        refresh_cycle_in <= 1'b0;
        $display("test strap done");
    endtask

    task automatic t_dma(input logic fit, input logic [3:0] dly);
        int c0, p0, k;
        c0 = n_cop;
        p0 = n_cpu;
        @(posedge clk_in);
        {copro_fitted_in, copro_busy_n_in, gnt_dly} <= {fit, 1'b0, dly};
        {dma_addr_in, dma_bhe_n_in} <= {20'h5a5a5, 1'b0};
        repeat (4) @(posedge clk_in);
        dma_req_in <= 1'b1;
        repeat (8) @(negedge clk_in);
        chk(n_cop + n_cpu, c0 + p0);
        @(posedge clk_in);
        copro_busy_n_in <= 1'b1;
        k = 0;
        while (dma_grant_out !== 1'b1 && k < 40) begin
            @(negedge clk_in);
            k++;
        end
        chk(dma_grant_out, 1'b1);
        chk(n_cop - c0, 32'(fit));
        chk(n_cpu - p0, 32'(!fit));
        chk({upper_sys_addr_oe_out, byte_high_enable_n_oe_out},
            2'h3);
        chk({upper_sys_addr_out, byte_high_enable_n_out}, 5'h0a);
        @(posedge clk_in);
        dma_addr_phase_in <= 1'b1;
        repeat (2) @(negedge clk_in);
        chk({muxed_addr_data_oe_out, muxed_addr_data_out},
            17'h1a5a5);
        @(posedge clk_in);
        {dma_addr_phase_in, dma_req_in, dma_done_in} <= 3'h1;
        @(posedge clk_in);
        dma_done_in <= 1'b0;
        repeat (3) @(negedge clk_in);
        chk({dma_grant_out, upper_sys_addr_oe_out, muxed_addr_data_oe_out,
            byte_high_enable_n_oe_out}, 4'h0);
        chk(n_cop - c0, {30'h0, fit, 1'b0});
        chk(n_cpu - p0, {30'h0, !fit, 1'b0});
        $display("test dma fitted=%0d delay=%0d done", fit, dly);
    endtask

    initial begin
        repeat (10) @(posedge clk_in);
        @(negedge clk_in);
        chk({base_bank_select_n_out, exp_bank_code_out}, 14'h3fff);
        chk({sys_ready_out, nmi_out, ack_gate_n_out, dma_grant_out},
            4'h2);
        repeat (6) @(posedge clk_in);
        rst_n_in <= 1'b1;
        repeat (4) @(posedge clk_in);
        $display("test reset done");
        t_mem();
        t_io();
        t_nmi();
        t_mode();
        t_dma(1'b1, 4'h0);
        t_dma(1'b1, 4'h6);
        t_dma(1'b0, 4'h2);
        stop_test();
    end
endmodule
`default_nettype wire
